// ==== core/hbs_pkg.sv ====
// Constants shared by the H-bridge fault and dead-time supervisor.
package hbs_pkg;

    // Core clock period in nanoseconds (10 MHz).
    localparam int CLK_NS = 100;

    // Register byte offsets on the AHB-Lite port.
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] CONFIG_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;

    // Control register fields.
    localparam int CTRL_DEAD_LSB = 0;
    localparam int CTRL_CLR_BIT  = 8;

    // Configuration register fields.
    localparam int CFG_VDS_LSB = 0;
    localparam int CFG_DRV_LSB = 4;

    // Status register fields.
    localparam int ST_OCP_BIT   = 0;
    localparam int ST_GDF_BIT   = 1;
    localparam int ST_SUV_BIT   = 2;
    localparam int ST_PUV_BIT   = 3;
    localparam int ST_RETRY_BIT = 8;
    localparam int ST_FAULT_BIT = 9;
    localparam int ST_GATE_LSB  = 12;

    // Values after reset: 240 ns dead time, open-input threshold and drive levels.
    localparam logic [1:0] DEAD_SEL_RST = 2'h1;
    localparam logic [2:0] VDS_SEL_RST  = 3'h3;
    localparam logic [2:0] DRV_SEL_RST  = 3'h3;

    // Threshold selector level that switches the drain-source monitor off.
    localparam logic [2:0] VDS_SEL_OFF = 3'h5;

    // Digital dead-time options in nanoseconds and their least cycle counts.
    localparam int DEAD0_NS = 120;
    localparam int DEAD1_NS = 240;
    localparam int DEAD2_NS = 480;
    localparam int DEAD3_NS = 960;
    localparam logic [3:0] DEAD_CYC [4] = '{4'((DEAD0_NS + CLK_NS - 1) / CLK_NS),
                                            4'((DEAD1_NS + CLK_NS - 1) / CLK_NS),
                                            4'((DEAD2_NS + CLK_NS - 1) / CLK_NS),
                                            4'((DEAD3_NS + CLK_NS - 1) / CLK_NS)};

    // Filter and protection times in their own units, and derived cycle counts.
    localparam int INPUT_DGL_NS = 400;
    localparam int OCP_DGL_NS   = 4000;
    localparam int DRIVE_NS     = 4000;
    localparam int RETRY_US     = 4000;
    localparam int INPUT_DGL_CYC = (INPUT_DGL_NS + CLK_NS - 1) / CLK_NS;
    localparam int OCP_DGL_CYC   = (OCP_DGL_NS + CLK_NS - 1) / CLK_NS;
    localparam int DRIVE_CYC     = DRIVE_NS / CLK_NS;
    localparam int RETRY_CYC     = (RETRY_US * 1000 + CLK_NS - 1) / CLK_NS;

    // Drain-source trip levels in millivolts; zero marks a disabled monitor.
    localparam logic [9:0] VDS_TRIP_MV [6] = '{10'h03C, 10'h078, 10'h0F0, 10'h1E0, 10'h3C0, 10'h000};

    // Peak source current in mA at the low supply point, high side and low side.
    localparam logic [7:0] DRV_HS_MA [6] = '{8'h0A, 8'h14, 8'h32, 8'h91, 8'hBE, 8'hF0};
    localparam logic [7:0] DRV_LS_MA [6] = '{8'h0A, 8'h14, 8'h28, 8'h73, 8'h91, 8'hBE};

    // Fault controller states.
    typedef enum logic [0:0] {
        FLT_RUN   = 1'b0,
        FLT_RETRY = 1'b1
    } hbs_flt_type;

endpackage

// ==== core/hbs_supervisor.sv ====
// H-bridge dead-time insertion, input filtering and fault supervision with an AHB-Lite register port.
//
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ns

// Notes on behaviour
// [RL1] Dead time selectable 120, 240, 480 or 960 ns; 240 ns after reset.
// [RL2] Conducting FET goes off first; switch node floats until dead time ends.
// [RL3] Bridge command inputs are deglitched; short pulses never reach the outputs.
// [RL4] Overcurrent only after a driven FET's comparator stays high beyond deglitch time.
// [RL5] Threshold selector decodes 0.06 to 0.96 V; reset value is the 0.48 V level.
// [RL6] Highest threshold level turns drain-source overcurrent monitoring off.
// [RL7] Overcurrent disables all FETs, pulls fault low, sets flag, retries later.
// [RL8] Persistent overcurrent repeats the retry cycle; otherwise drive resumes, fault released.
// [RL9] Overcurrent flag stays set until the clear-faults command.
// [RL10] Sense-pin comparator also sets the overcurrent flag and pulls fault low.
// [RL11] Gate fault when gate monitor disagrees with command after the drive interval.
// [RL12] Gate fault disables FETs, pulls fault low, sets flag, retries after retry time.
// [RL13] Gate-fault flag stays set until the clear-faults command.
// [RL14] Supply undervoltage disables FETs and pump, pulls fault low, sets flag.
// [RL15] After supply recovery fault is released but its flag stays until cleared.
// [RL16] Supply undervoltage keeps configuration and internal logic intact.
// [RL17] Logic undervoltage resets logic and settings, holds fault low, then resumes.
// [RL18] Pump undervoltage disables FETs, pulls fault low, sets flag, resumes on recovery.
// [RL19] After pump recovery fault is released while its flag stays until cleared.
// [RL20] Drive strength selector decodes six levels; open level gives 145/115 mA.
// [RL21] Fault output is open-drain and active low while any fault is present.
// [RL22] Fault output ORs all active faults; bridge runs only with none left.
module hbs_supervisor #(
    parameter int RETRY_CYC = hbs_pkg::RETRY_CYC
) (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rstn,
    // AHB-Lite register port.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Half-bridge commands from the controller, one bit per half-bridge.
    input  wire logic [1:0]  half_enable,
    input  wire logic [1:0]  half_high,
    // Analog monitors: order is high side 0, high side 1, low side 0, low side 1.
    input  wire logic [3:0]  vds_over,
    input  wire logic [3:0]  gate_level,
    input  wire logic        sense_pin_over,
    // Supply indications.
    input  wire logic        supply_undervoltage,
    input  wire logic        pump_undervoltage,
    input  wire logic        logic_undervoltage,
    // Gate drive commands toward the external bridge.
    output logic [1:0]       gate_high_on,
    output logic [1:0]       gate_low_on,
    output logic             charge_pump_en,
    // Analog settings decoded from the selectors.
    output logic [9:0]       vds_trip_mv,
    output logic             vds_monitor_en,
    output logic [7:0]       drive_hs_ma,
    output logic [7:0]       drive_ls_ma,
    // Open-drain fault line, active low.
    output logic             fault_out_n_o,
    output logic             fault_out_n_oe
);

    // Internal reset: logic undervoltage acts like the reset pin.
    logic       raw_rstn;
    logic       rst_meta_ff;
    logic       rst_sync_ff;

    // Register bus state.
    logic       dp_valid_ff;
    logic       dp_write_ff;
    logic [7:0] dp_addr_ff;
    logic [31:0] hrdata_ff;
    logic       addr_phase;

    // Configuration and commands.
    logic [1:0] dead_sel_ff;
    logic [2:0] drain_source_threshold_sel_ff;
    logic [2:0] gate_drive_strength_sel_ff;
    logic       clear_faults_cmd;

    // Input filters.
    logic [1:0] cmd_en_ff;
    logic [1:0] cmd_hi_ff;

    // Gate outputs and dead-time counters.
    logic [1:0] gh_ff;
    logic [1:0] gl_ff;
    logic [3:0] dead_cnt_ff [2];
    logic [3:0] fet_on;

    // Fault detection and control.
    logic [3:0] ocp_evt;
    logic [3:0] gdf_evt;
    logic       oc_evt;
    logic       gd_evt;
    logic       trip;
    logic       bridge_en;
    hbs_pkg::hbs_flt_type flt_ff;
    logic [31:0] retry_cnt_ff;
    logic       overcurrent_flag_ff;
    logic       gate_fault_flag_ff;
    logic       supply_uv_flag_ff;
    logic       pump_uv_flag_ff;
    logic       fault_oe_ff;
    logic       cp_en_ff;
    logic [9:0] vds_mv_ff;
    logic       vds_en_ff;
    logic [7:0] drv_hs_ff;
    logic [7:0] drv_ls_ff;

    // Working signals for filters, monitors and register decode.
    logic [2:0]  en_cnt_ff [2];
    logic [2:0]  hi_cnt_ff [2];
    logic [1:0]  want_high;
    logic [1:0]  want_low;
    logic [5:0]  ocp_cnt_ff [4];
    logic [5:0]  gdf_cnt_ff [4];
    logic        uv_block;
    logic        wr_ctrl;
    logic        wr_cfg;
    logic [31:0] rd_word;

    // Logic undervoltage clears everything, exactly like the reset pin.
    assign raw_rstn = rstn & ~logic_undervoltage; // RL17

    // Reset release passes two stages; assertion is immediate, release is clean.
    always_ff @(posedge clk or negedge raw_rstn) begin
        if (!raw_rstn) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // An address phase is taken when selected, ready and the transfer is active.
    assign addr_phase = hsel && hready && htrans[1];

    // The slave answers every transfer at once and never signals an error.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_ff;

    // Address phase information is kept for the following data phase.
    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            dp_valid_ff <= 1'b0;
            dp_write_ff <= 1'b0;
            dp_addr_ff  <= 8'h00;
        end else begin
            dp_valid_ff <= addr_phase;
            dp_write_ff <= hwrite;
            dp_addr_ff  <= haddr[7:0];
        end
    end

    // Write strobes are formed in the data phase, where the write data stands.
    assign wr_ctrl = dp_valid_ff && dp_write_ff && (dp_addr_ff == hbs_pkg::CTRL_OFS);
    assign wr_cfg  = dp_valid_ff && dp_write_ff && (dp_addr_ff == hbs_pkg::CONFIG_OFS);

    // The clear command is a single-cycle strobe, so no stale clear is replayed.
    assign clear_faults_cmd = wr_ctrl && hwdata[hbs_pkg::CTRL_CLR_BIT]; // RL9 RL13

    // Read word selected from the address phase address.
    always_comb begin
        rd_word = 32'h0000_0000;
        case (haddr[7:0])
            hbs_pkg::CTRL_OFS: begin
                rd_word[hbs_pkg::CTRL_DEAD_LSB +: 2] = dead_sel_ff;
            end
            hbs_pkg::CONFIG_OFS: begin
                rd_word[hbs_pkg::CFG_VDS_LSB +: 3] = drain_source_threshold_sel_ff;
                rd_word[hbs_pkg::CFG_DRV_LSB +: 3] = gate_drive_strength_sel_ff;
            end
            hbs_pkg::STATUS_OFS: begin
                rd_word[hbs_pkg::ST_OCP_BIT]         = overcurrent_flag_ff;
                rd_word[hbs_pkg::ST_GDF_BIT]         = gate_fault_flag_ff;
                rd_word[hbs_pkg::ST_SUV_BIT]         = supply_uv_flag_ff;
                rd_word[hbs_pkg::ST_PUV_BIT]         = pump_uv_flag_ff;
                rd_word[hbs_pkg::ST_RETRY_BIT]       = (flt_ff == hbs_pkg::FLT_RETRY);
                rd_word[hbs_pkg::ST_FAULT_BIT]       = fault_oe_ff;
                rd_word[hbs_pkg::ST_GATE_LSB +: 4]   = gate_level;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // Read data is latched at the end of the address phase and held through the data phase.
    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            hrdata_ff <= rd_word;
        end
    end

    // Configuration; supply undervoltage does not touch it, only a reset does.
    // Out-of-range selector codes saturate so the decode tables are never overrun.
    always_ff @(posedge clk or negedge rst_sync_ff) begin // RL16
        if (!rst_sync_ff) begin
            dead_sel_ff                   <= hbs_pkg::DEAD_SEL_RST; // RL1
            drain_source_threshold_sel_ff <= hbs_pkg::VDS_SEL_RST; // RL5
            gate_drive_strength_sel_ff    <= hbs_pkg::DRV_SEL_RST; // RL20
        end else begin
            if (wr_ctrl) begin
                dead_sel_ff <= hwdata[hbs_pkg::CTRL_DEAD_LSB +: 2]; // RL1
            end
            if (wr_cfg) begin
                if (hwdata[hbs_pkg::CFG_VDS_LSB +: 3] > hbs_pkg::VDS_SEL_OFF) begin
                    drain_source_threshold_sel_ff <= hbs_pkg::VDS_SEL_OFF;
                end else begin
                    drain_source_threshold_sel_ff <= hwdata[hbs_pkg::CFG_VDS_LSB +: 3];
                end
                if (hwdata[hbs_pkg::CFG_DRV_LSB +: 3] > 3'h5) begin
                    gate_drive_strength_sel_ff <= 3'h5;
                end else begin
                    gate_drive_strength_sel_ff <= hwdata[hbs_pkg::CFG_DRV_LSB +: 3];
                end
            end
        end
    end

    // Selector decode toward the analog comparators and gate drivers.
    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            vds_mv_ff <= hbs_pkg::VDS_TRIP_MV[3];
            vds_en_ff <= 1'b1;
            drv_hs_ff <= hbs_pkg::DRV_HS_MA[3];
            drv_ls_ff <= hbs_pkg::DRV_LS_MA[3];
        end else begin
            vds_mv_ff <= hbs_pkg::VDS_TRIP_MV[drain_source_threshold_sel_ff]; // RL5
            vds_en_ff <= (drain_source_threshold_sel_ff != hbs_pkg::VDS_SEL_OFF); // RL6
            drv_hs_ff <= hbs_pkg::DRV_HS_MA[gate_drive_strength_sel_ff]; // RL20
            drv_ls_ff <= hbs_pkg::DRV_LS_MA[gate_drive_strength_sel_ff]; // RL20
        end
    end

    assign vds_trip_mv    = vds_mv_ff;
    assign vds_monitor_en = vds_en_ff;
    assign drive_hs_ma    = drv_hs_ff;
    assign drive_ls_ma    = drv_ls_ff;

    // Per half-bridge: input filters, wanted state and dead-time sequencing.
    for (genvar h = 0; h < 2; h++) begin : g_half
        // The filtered enable follows only after a steady run of differing samples.
        always_ff @(posedge clk or negedge rst_sync_ff) begin
            if (!rst_sync_ff) begin
                cmd_en_ff[h] <= 1'b0;
                en_cnt_ff[h] <= 3'h0;
            end else if (half_enable[h] == cmd_en_ff[h]) begin
                en_cnt_ff[h] <= 3'h0;
            end else if (en_cnt_ff[h] == 3'(hbs_pkg::INPUT_DGL_CYC - 1)) begin
                cmd_en_ff[h] <= half_enable[h]; // RL3
                en_cnt_ff[h] <= 3'h0;
            end else begin
                en_cnt_ff[h] <= en_cnt_ff[h] + 3'h1;
            end
        end

        // The phase input is filtered the same way, so a noise pulse never moves a gate.
        always_ff @(posedge clk or negedge rst_sync_ff) begin
            if (!rst_sync_ff) begin
                cmd_hi_ff[h] <= 1'b0;
                hi_cnt_ff[h] <= 3'h0;
            end else if (half_high[h] == cmd_hi_ff[h]) begin
                hi_cnt_ff[h] <= 3'h0;
            end else if (hi_cnt_ff[h] == 3'(hbs_pkg::INPUT_DGL_CYC - 1)) begin
                cmd_hi_ff[h] <= half_high[h]; // RL3
                hi_cnt_ff[h] <= 3'h0;
            end else begin
                hi_cnt_ff[h] <= hi_cnt_ff[h] + 3'h1;
            end
        end

        // Any disabling condition removes both wanted gates at once.
        assign want_high[h] = bridge_en && cmd_en_ff[h] && cmd_hi_ff[h]; // RL22
        assign want_low[h]  = bridge_en && cmd_en_ff[h] && !cmd_hi_ff[h]; // RL22

        // A conducting gate that is no longer wanted goes off first; the new one waits for the dead time.
        always_ff @(posedge clk or negedge rst_sync_ff) begin
            if (!rst_sync_ff) begin
                gh_ff[h]       <= 1'b0;
                gl_ff[h]       <= 1'b0;
                dead_cnt_ff[h] <= hbs_pkg::DEAD_CYC[1];
            end else if ((gh_ff[h] && !want_high[h]) || (gl_ff[h] && !want_low[h])) begin
                gh_ff[h]       <= 1'b0; // RL2
                gl_ff[h]       <= 1'b0; // RL2
                dead_cnt_ff[h] <= hbs_pkg::DEAD_CYC[dead_sel_ff]; // RL1
            end else if (dead_cnt_ff[h] != 4'h0) begin
                dead_cnt_ff[h] <= dead_cnt_ff[h] - 4'h1; // RL2
            end else begin
                gh_ff[h] <= want_high[h];
                gl_ff[h] <= want_low[h];
            end
        end
    end

    assign gate_high_on = gh_ff;
    assign gate_low_on  = gl_ff;
    assign fet_on       = {gl_ff, gh_ff};

    // Per FET: drain-source and gate-level monitors with their own deglitch counters.
    for (genvar f = 0; f < 4; f++) begin : g_fet
        // The count saturates, so a persistent overload keeps the event asserted.
        always_ff @(posedge clk or negedge rst_sync_ff) begin
            if (!rst_sync_ff) begin
                ocp_cnt_ff[f] <= 6'h00;
            end else if (fet_on[f] && vds_over[f] && vds_en_ff) begin // RL4 RL6
                if (ocp_cnt_ff[f] != 6'(hbs_pkg::OCP_DGL_CYC)) begin
                    ocp_cnt_ff[f] <= ocp_cnt_ff[f] + 6'h01;
                end
            end else begin
                ocp_cnt_ff[f] <= 6'h00;
            end
        end

        // Only a driven FET over threshold past the deglitch time counts as overload.
        assign ocp_evt[f] = fet_on[f] && vds_over[f] && vds_en_ff
                            && (ocp_cnt_ff[f] == 6'(hbs_pkg::OCP_DGL_CYC)); // RL4

        // A gate that has not followed its command by the end of peak drive is a fault.
        always_ff @(posedge clk or negedge rst_sync_ff) begin
            if (!rst_sync_ff) begin
                gdf_cnt_ff[f] <= 6'h00;
            end else if (fet_on[f] != gate_level[f]) begin
                if (gdf_cnt_ff[f] != 6'(hbs_pkg::DRIVE_CYC)) begin
                    gdf_cnt_ff[f] <= gdf_cnt_ff[f] + 6'h01;
                end
            end else begin
                gdf_cnt_ff[f] <= 6'h00;
            end
        end

        assign gdf_evt[f] = (fet_on[f] != gate_level[f])
                            && (gdf_cnt_ff[f] == 6'(hbs_pkg::DRIVE_CYC)); // RL11
    end

    // Fault sources combined; the sense pin trips without a deglitch of its own.
    assign oc_evt    = (|ocp_evt) || sense_pin_over; // RL7 RL10
    assign gd_evt    = |gdf_evt; // RL11 RL12
    assign trip      = oc_evt || gd_evt;
    assign uv_block  = supply_undervoltage || pump_undervoltage; // RL14 RL18
    assign bridge_en = (flt_ff == hbs_pkg::FLT_RUN) && !trip && !uv_block; // RL22

    // Retry timer: a trip during retry restarts it, so a lasting fault repeats the cycle.
    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            flt_ff       <= hbs_pkg::FLT_RUN;
            retry_cnt_ff <= 32'h0000_0000;
        end else begin
            case (flt_ff)
                hbs_pkg::FLT_RUN: begin
                    if (trip) begin
                        flt_ff       <= hbs_pkg::FLT_RETRY; // RL7 RL12
                        retry_cnt_ff <= 32'(RETRY_CYC - 1);
                    end
                end
                hbs_pkg::FLT_RETRY: begin
                    if (trip) begin
                        retry_cnt_ff <= 32'(RETRY_CYC - 1); // RL8
                    end else if (retry_cnt_ff == 32'h0000_0000) begin
                        flt_ff <= hbs_pkg::FLT_RUN; // RL8
                    end else begin
                        retry_cnt_ff <= retry_cnt_ff - 32'h0000_0001;
                    end
                end
                default: begin
                    flt_ff <= hbs_pkg::FLT_RUN;
                end
            endcase
        end
    end

    // Sticky flags; when an event and a clear meet in one cycle the event wins.
    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            overcurrent_flag_ff <= 1'b0;
            gate_fault_flag_ff  <= 1'b0;
            supply_uv_flag_ff   <= 1'b0;
            pump_uv_flag_ff     <= 1'b0;
        end else begin
            overcurrent_flag_ff <= oc_evt || (overcurrent_flag_ff && !clear_faults_cmd); // RL9 RL10
            gate_fault_flag_ff  <= gd_evt || (gate_fault_flag_ff && !clear_faults_cmd); // RL13
            supply_uv_flag_ff   <= supply_undervoltage || (supply_uv_flag_ff && !clear_faults_cmd); // RL15
            pump_uv_flag_ff     <= pump_undervoltage || (pump_uv_flag_ff && !clear_faults_cmd); // RL19
        end
    end

    // The fault line is pulled low during reset and while any condition or retry is active.
    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            fault_oe_ff <= 1'b1; // RL17
        end else begin
            fault_oe_ff <= trip || uv_block || (flt_ff == hbs_pkg::FLT_RETRY); // RL21 RL22
        end
    end

    // The charge pump stops for supply undervoltage and is held off during reset or logic undervoltage.
    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            cp_en_ff <= 1'b0;
        end else begin
            cp_en_ff <= !supply_undervoltage; // RL14
        end
    end

    // Open-drain pin: the driven level is always low, only the enable moves.
    assign charge_pump_en = cp_en_ff;
    assign fault_out_n_o  = 1'b0; // RL21
    assign fault_out_n_oe = fault_oe_ff; // RL21

endmodule

// ==== verification/hbs_bridge_model.sv ====
// Model of the external MOSFET bridge and its monitors.
`timescale 1ns/1ns
module hbs_bridge_model (
    // Gate commands and fault injection.
    input  wire logic [1:0] gate_high_on,
    input  wire logic [1:0] gate_low_on,
    input  wire logic [3:0] short_fet,
    input  wire logic [3:0] stuck_gate,
    // Monitor outputs.
    output logic      [3:0] vds_over,
    output logic      [3:0] gate_level
);
    // A stuck gate always reads low whatever its command; a short only shows on a FET that conducts.
    assign gate_level = {gate_low_on, gate_high_on} & ~stuck_gate;
    assign vds_over   = short_fet & {gate_low_on, gate_high_on};
endmodule

// ==== verification/hbs_checker.sv ====
// Assertions on the ports of the H-bridge supervisor.
`timescale 1ns/1ns
module hbs_checker (
    // Clock, reset and watched signals.
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       supply_undervoltage,
    input wire logic       pump_undervoltage,
    input wire logic       logic_undervoltage,
    input wire logic       sense_pin_over,
    input wire logic [1:0] gate_high_on,
    input wire logic [1:0] gate_low_on,
    input wire logic       charge_pump_en,
    input wire logic [9:0] vds_trip_mv,
    input wire logic       vds_monitor_en,
    input wire logic       fault_out_n_o,
    input wire logic       fault_out_n_oe
);
    // One domain, so one clock and reset for all.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire off = (gate_high_on == 2'h0) && (gate_low_on == 2'h0);
    no_shoot_a: assert property ((gate_high_on & gate_low_on) == 2'h0) else $error("shoot through");
    dead_gap_a: assert property ($fell(gate_high_on[0]) |-> !gate_low_on[0] [*2]) else $error("gap short");
    open_drain_a: assert property (fault_out_n_oe |-> !fault_out_n_o) else $error("fault high");
    supply_off_a: assert property (supply_undervoltage [*8] |-> off && !charge_pump_en && fault_out_n_oe)
        else $error("supply uv");
    pump_off_a: assert property (pump_undervoltage [*8] |-> off && fault_out_n_oe) else $error("pump uv");
    logic_uv_a: assert property (logic_undervoltage [*8] |-> fault_out_n_oe) else $error("logic uv");
    sense_trip_a: assert property ($rose(sense_pin_over) |-> ##[0:60] fault_out_n_oe) else $error("sense");
    monitor_off_a: assert property (vds_monitor_en == (vds_trip_mv != 10'h000)) else $error("monitor");
    // Main scenarios.
    cover property ($rose(fault_out_n_oe));
    cover property ($fell(gate_high_on[0]));
    cover property (supply_undervoltage [*8]);
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench for the H-bridge supervisor.
`timescale 1ns/1ns
module tb_top;
    logic        clk, rstn, hrdy, hwrite, hresp, spo, suv, puv, luv, cpen, mon, fo, foe;
    logic [1:0]  htrans, en, hi, gh, gl;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [3:0]  drain_source_threshold_sel, gate, shrt, stuck;
    logic [9:0]  trip;
    logic [7:0]  hs, ls;
    logic [9:0]  tbl [6] = '{10'h03C, 10'h078, 10'h0F0, 10'h1E0, 10'h3C0, 10'h000};
    int          num_errors = 0, checked = 0, cyc = 0;
    wire         fault_n = foe ? fo : 1'b1;
    // Short retry keeps the run brief.
    hbs_supervisor #(.RETRY_CYC(200)) dut (.clk(clk), .rstn(rstn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(hresp),
        .hrdata(hrdata), .half_enable(en), .half_high(hi), .vds_over(drain_source_threshold_sel), .gate_level(gate),
        .sense_pin_over(spo), .supply_undervoltage(suv), .pump_undervoltage(puv), .logic_undervoltage(luv),
        .gate_high_on(gh), .gate_low_on(gl), .charge_pump_en(cpen), .vds_trip_mv(trip),
        .vds_monitor_en(mon), .drive_hs_ma(hs), .drive_ls_ma(ls), .fault_out_n_o(fo), .fault_out_n_oe(foe));
    hbs_bridge_model fets (.gate_high_on(gh), .gate_low_on(gl), .short_fet(shrt), .stuck_gate(stuck),
        .vds_over(drain_source_threshold_sel), .gate_level(gate));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One AHB-Lite single transfer; read data lands in rd.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        rd = hrdata;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Clock at 10 MHz and a bound on the run.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 12000) begin
            num_errors++;
            finish_test();
        end
    end
    // Main sequence.
    initial begin
        {rstn, htrans, hwrite, haddr, hwdata, en, hi, spo, suv, puv, luv, shrt, stuck} = '0;
        tick(12);
        rstn <= 1'b1;
        tick(4);
        bus(0, hbs_pkg::CTRL_OFS, 0);
        chk("dead", rd[1:0], 2'h1);
        chk("drive", {hs, ls}, 16'h9173);
        for (int i = 0; i < 6; i++) begin
            bus(1, hbs_pkg::CONFIG_OFS, i);
            tick(2);
            chk("trip", trip, tbl[i]);
            chk("mon", mon, i != 5);
        end
        bus(1, hbs_pkg::CONFIG_OFS, 32'h33);
        en <= 2'h1;
        hi <= 2'h1;
        tick(1);
        hi <= 2'h0;
        tick(30);
        chk("glitch", {gh[0], gl[0]}, 2'h1);
        shrt <= 4'h4;
        tick(60);
        chk("ocp", {fault_n, gl[0]}, 2'h0);
        shrt <= 4'h0;
        tick(400);
        chk("resume", {fault_n, gl[0]}, 2'h3);
        bus(0, hbs_pkg::STATUS_OFS, 0);
        chk("ocpflag", rd[hbs_pkg::ST_OCP_BIT], 1'b1);
        stuck <= 4'h1;
        hi <= 2'h1;
        tick(80);
        stuck <= 4'h0;
        spo <= 1'b1;
        tick(60);
        spo <= 1'b0;
        tick(400);
        bus(0, hbs_pkg::STATUS_OFS, 0);
        chk("gdf", rd[hbs_pkg::ST_GDF_BIT], 1'b1);
        bus(1, hbs_pkg::CTRL_OFS, 32'h101);
        bus(1, hbs_pkg::CONFIG_OFS, 32'h11);
        bus(0, hbs_pkg::STATUS_OFS, 0);
        chk("clear", rd[1:0], 2'h0);
        {suv, puv} <= 2'h3;
        tick(12);
        {suv, puv} <= 2'h0;
        tick(40);
        chk("uvrel", fault_n, 1'b1);
        bus(0, hbs_pkg::STATUS_OFS, 0);
        chk("uvflags", rd[3:2], 2'h3);
        bus(0, hbs_pkg::CONFIG_OFS, 0);
        chk("kept", rd[6:0], 7'h11);
        luv <= 1'b1;
        tick(12);
        luv <= 1'b0;
        tick(20);
        bus(0, hbs_pkg::CONFIG_OFS, 0);
        chk("lost", rd[6:0], 7'h33);
        finish_test();
    end
endmodule
bind hbs_supervisor hbs_checker chk_i (.clk(clk), .rstn(rstn), .supply_undervoltage(supply_undervoltage),
    .pump_undervoltage(pump_undervoltage), .logic_undervoltage(logic_undervoltage),
    .sense_pin_over(sense_pin_over), .gate_high_on(gate_high_on), .gate_low_on(gate_low_on),
    .charge_pump_en(charge_pump_en), .vds_trip_mv(vds_trip_mv), .vds_monitor_en(vds_monitor_en),
    .fault_out_n_o(fault_out_n_o), .fault_out_n_oe(fault_out_n_oe));
